/* File: core/uim_regs.vh */
// Register map, field positions and reset values for the USB
// interface manager flag routing and transceiver control block.
// Assumes word offsets on an 8-bit register address, 32-bit data.
`ifndef UIM_REGS_VH
`define UIM_REGS_VH

// Register offsets
`define UIM_OFF_STATE_RESET 8'h00
`define UIM_OFF_SIGNAL_FLAG_SET 8'h1c
`define UIM_OFF_FLAG_STICKY_SELECT 8'h20
`define UIM_OFF_FLAG_PORT_MASKS 8'h24
`define UIM_OFF_FRAME_START_COUNT 8'h28
`define UIM_OFF_LAST_PACKET_ID 8'h2c
`define UIM_OFF_LAST_ENDPOINT 8'h30
`define UIM_OFF_ENDPOINT_SPECIAL_MARK 8'h34
`define UIM_OFF_OTG_FLAG_MASK 8'h38
`define UIM_OFF_POWER_SIGNAL_WORD 8'h3c
`define UIM_OFF_TRANSCEIVER_CONTROL 8'h40

// Signal flag bit positions
`define UIM_FLAG_RX_ERROR 0
`define UIM_FLAG_RX_ACTIVE 1
`define UIM_FLAG_CRC16_FAIL 2
`define UIM_FLAG_LINE_J 3
`define UIM_FLAG_LINE_K 4
`define UIM_FLAG_LINE_SE0 5
`define UIM_FLAG_TOKEN_OK 6

// Port mask byte positions
`define UIM_MASK_A_LSB 0
`define UIM_MASK_B_LSB 8
`define UIM_MASK_C_LSB 16

// Last endpoint valid bit, special endpoint marker value
`define UIM_EP_VALID_BIT 4
`define UIM_EP_SPECIAL 5'h10

// Transceiver control fields
`define UIM_PHY_PD_DISABLE 18
`define UIM_PHY_RESET_CAUSE 13
`define UIM_PHY_RESUME_CAUSE 12
`define UIM_PHY_FILT_LSB 8
`define UIM_PHY_SUSP_HW 7
`define UIM_PHY_CONF_LSB 4

// Linestate encodings
`define UIM_LS_SE0 2'h0
`define UIM_LS_J 2'h1
`define UIM_LS_K 2'h2

// Reset values
`define UIM_RST_WORD 32'h0000_0000
`define UIM_RST_FLAGS 7'h00
`define UIM_RST_PHY_CTRL 19'h0_0000

`endif

/* File: core/uim_core.v */
// USB interface manager: signal flags, notify ports, packet capture
// and transceiver control behind a 32-bit peripheral register port.
// Assumes UTMI+ side inputs share sys_clk_i with the register port.
//
// Overview of operation
// - Sticky-select bit per flag, seven bits
// - Sticky flag holds until written one
// - Non-sticky level flag follows its source signal
// - Three notify ports, OR of masked flags
// - Eleven-bit frame counter, software read/write
// - Last received packet id captured read-only
// - Last received endpoint number captured read-only
// - Endpoint valid bit marks captured endpoint
// - Marked endpoints presented ORed with 0x10
// - Pulldown-disable bit turns transceiver pulldowns off
// - SE0 auto-resume sets reset cause, write-0 clears
// - K auto-resume sets resume cause, write-0 clears
// - Linestate propagates after 2^filter stable cycles
// - Suspend-handler bit selects hardware resume
// - Config field drives transceiver config pins
// - Seven flags: errors, activity, linestate, token
// - Non-sticky event flags clear on next packet
`timescale 1ns/100ps
`include "uim_regs.vh"

module uim_core (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    output reg [31:0] reg_rdata_o,
    input wire rx_error_i,
    input wire rx_active_i,
    input wire crc16_fail_i,
    input wire token_ok_i,
    input wire pkt_start_i,
    input wire pid_valid_i,
    input wire [3:0] pid_i,
    input wire ep_valid_i,
    input wire [3:0] ep_i,
    input wire sof_valid_i,
    input wire [10:0] sof_frame_i,
    input wire [1:0] linestate_i,
    input wire suspend_i,
    output reg notify_port_a_o,
    output reg notify_port_b_o,
    output reg notify_port_c_o,
    output reg [4:0] rx_ep_o,
    output reg [1:0] linestate_filt_o,
    output reg auto_resume_o,
    output reg suspend_hw_o,
    output reg transceiver_port_a_pulldown_o,
    output reg transceiver_port_b_pulldown_o,
    output reg [2:0] transceiver_config_pins_o,
    output reg [31:0] otg_flag_mask_o,
    output reg [8:0] power_signal_o
);

    // Address match for a write strobe
    function sel;
        input [7:0] addr;
        input [7:0] off;
        begin
            sel = (addr == off);
        end
    endfunction

    // Software visible storage
    reg [6:0] signal_flag_set; // Live flags
    reg [6:0] flag_sticky_select; // Sticky choice per flag
    reg [23:0] flag_port_masks; // Three mask bytes
    reg [10:0] frame_start_count; // Frame counter
    reg [3:0] last_packet_id; // Last pid
    reg [3:0] last_endpoint; // Last endpoint
    reg last_endpoint_valid; // Endpoint field valid
    reg [15:0] endpoint_special_mark; // Special endpoint marks
    reg [18:0] transceiver_control; // Phy control bits

    // Linestate filter state
    reg [1:0] ls_cand; // Candidate linestate
    reg [15:0] ls_stable; // Cycles candidate held

    // Write strobes
    wire wr_srst = reg_wr_i & sel(reg_addr_i, `UIM_OFF_STATE_RESET);
    wire wr_flags = reg_wr_i & sel(reg_addr_i, `UIM_OFF_SIGNAL_FLAG_SET);
    wire wr_sticky = reg_wr_i & sel(reg_addr_i, `UIM_OFF_FLAG_STICKY_SELECT);
    wire wr_masks = reg_wr_i & sel(reg_addr_i, `UIM_OFF_FLAG_PORT_MASKS);
    wire wr_sof = reg_wr_i & sel(reg_addr_i, `UIM_OFF_FRAME_START_COUNT);
    wire wr_mark = reg_wr_i & sel(reg_addr_i, `UIM_OFF_ENDPOINT_SPECIAL_MARK);
    wire wr_otg = reg_wr_i & sel(reg_addr_i, `UIM_OFF_OTG_FLAG_MASK);
    wire wr_pwr = reg_wr_i & sel(reg_addr_i, `UIM_OFF_POWER_SIGNAL_WORD);
    wire wr_phy = reg_wr_i & sel(reg_addr_i, `UIM_OFF_TRANSCEIVER_CONTROL);

    // Phy control fields
    wire [3:0] filt_log2 = transceiver_control[`UIM_PHY_FILT_LSB +: 4];
    wire susp_hw = transceiver_control[`UIM_PHY_SUSP_HW];

    // Raw flag sources: levels and one-cycle events
    reg [6:0] flag_raw;
    // Value a non-sticky flag takes this cycle
    reg [6:0] flag_track;
    // Bits cleared by a software write of one
    wire [6:0] flag_clr = wr_flags ? reg_wdata_i[6:0] : 7'h00;

    // Flag sources from transceiver and packet decoder
    always @*
    begin
        flag_raw[`UIM_FLAG_RX_ERROR] = rx_error_i;
        flag_raw[`UIM_FLAG_RX_ACTIVE] = rx_active_i;
        flag_raw[`UIM_FLAG_CRC16_FAIL] = crc16_fail_i;
        flag_raw[`UIM_FLAG_LINE_J] = (linestate_filt_o == `UIM_LS_J);
        flag_raw[`UIM_FLAG_LINE_K] = (linestate_filt_o == `UIM_LS_K);
        flag_raw[`UIM_FLAG_LINE_SE0] = (linestate_filt_o == `UIM_LS_SE0);
        flag_raw[`UIM_FLAG_TOKEN_OK] = token_ok_i;
        // Level flags follow the signal
        flag_track = flag_raw;
        // Event flags hold until the next packet starts
        flag_track[`UIM_FLAG_CRC16_FAIL] = crc16_fail_i |
            (signal_flag_set[`UIM_FLAG_CRC16_FAIL] & ~pkt_start_i);
        flag_track[`UIM_FLAG_TOKEN_OK] = token_ok_i |
            (signal_flag_set[`UIM_FLAG_TOKEN_OK] & ~pkt_start_i);
    end

    // Per-flag update, sticky or tracking
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1)
        begin : g_flag
            always @(posedge sys_clk_i)
            begin
                if (!rst_n_i || wr_srst)
                    signal_flag_set[gi] <= 1'b0;
                else if (flag_sticky_select[gi])
                    // Capture wins over a same-cycle clear
                    signal_flag_set[gi] <= flag_raw[gi] |
                        (signal_flag_set[gi] & ~flag_clr[gi]);
                else
                    signal_flag_set[gi] <= flag_track[gi];
            end
        end
    endgenerate

    // Notify ports from masked flags
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            notify_port_a_o <= 1'b0;
            notify_port_b_o <= 1'b0;
            notify_port_c_o <= 1'b0;
        end
        else
        begin
            notify_port_a_o <= |(signal_flag_set &
                flag_port_masks[`UIM_MASK_A_LSB +: 7]);
            notify_port_b_o <= |(signal_flag_set &
                flag_port_masks[`UIM_MASK_B_LSB +: 7]);
            notify_port_c_o <= |(signal_flag_set &
                flag_port_masks[`UIM_MASK_C_LSB +: 7]);
        end
    end

    // Plain configuration registers
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            flag_sticky_select <= `UIM_RST_FLAGS;
            flag_port_masks <= 24'h00_0000;
            endpoint_special_mark <= 16'h0000;
            otg_flag_mask_o <= `UIM_RST_WORD;
            power_signal_o <= 9'h000;
        end
        else
        begin
            // Only defined bits are stored
            if (wr_sticky)
                flag_sticky_select <= reg_wdata_i[6:0];
            if (wr_masks)
                flag_port_masks <= reg_wdata_i[23:0];
            if (wr_mark)
                endpoint_special_mark <= reg_wdata_i[15:0];
            if (wr_otg)
                otg_flag_mask_o <= reg_wdata_i;
            if (wr_pwr)
                power_signal_o <= reg_wdata_i[8:0];
        end
    end

    // Frame counter, pid and endpoint capture
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i || wr_srst)
        begin
            frame_start_count <= 11'h000;
            last_packet_id <= 4'h0;
            last_endpoint <= 4'h0;
            last_endpoint_valid <= 1'b0;
            rx_ep_o <= 5'h00;
        end
        else
        begin
            // Received frame number beats a software write
            if (sof_valid_i)
                frame_start_count <= sof_frame_i;
            else if (wr_sof)
                frame_start_count <= reg_wdata_i[10:0];
            if (pid_valid_i)
                last_packet_id <= pid_i;
            if (ep_valid_i)
            begin
                last_endpoint <= ep_i;
                last_endpoint_valid <= 1'b1;
                // Marked endpoints carry the special bit
                rx_ep_o <= {1'b0, ep_i} |
                    (endpoint_special_mark[ep_i] ? `UIM_EP_SPECIAL : 5'h00);
            end
        end
    end

    // Linestate filter: hold candidate for 2^n cycles
    wire [15:0] ls_need = 16'h0001 << filt_log2;
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i || wr_srst)
        begin
            ls_cand <= `UIM_LS_SE0;
            ls_stable <= 16'h0000;
            linestate_filt_o <= `UIM_LS_SE0;
        end
        else if (linestate_i != ls_cand)
        begin
            // New value restarts the stability count
            ls_cand <= linestate_i;
            ls_stable <= 16'h0001;
            if (ls_need == 16'h0001)
                linestate_filt_o <= linestate_i;
        end
        else
        begin
            if (ls_stable != 16'hffff)
                ls_stable <= ls_stable + 16'h0001;
            if (ls_stable + 16'h0001 >= ls_need)
                linestate_filt_o <= ls_cand;
        end
    end

    // Resume detection while suspended under hardware control
    reg [1:0] ls_prev; // Filtered linestate last cycle
    wire ls_edge = (linestate_filt_o != ls_prev);
    wire resume_k = suspend_i & susp_hw & ls_edge &
        (linestate_filt_o == `UIM_LS_K);
    wire resume_se0 = suspend_i & susp_hw & ls_edge &
        (linestate_filt_o == `UIM_LS_SE0);
    wire phy_clr = wr_phy; // Write of zero clears a cause bit

    // Transceiver control register and cause bits
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            transceiver_control <= `UIM_RST_PHY_CTRL;
            ls_prev <= `UIM_LS_SE0;
            auto_resume_o <= 1'b0;
        end
        else
        begin
            ls_prev <= wr_srst ? `UIM_LS_SE0 : linestate_filt_o; // No false edge on soft reset
            auto_resume_o <= resume_k | resume_se0;
            if (wr_phy)
            begin
                transceiver_control[`UIM_PHY_PD_DISABLE] <=
                    reg_wdata_i[`UIM_PHY_PD_DISABLE];
                transceiver_control[11:4] <= reg_wdata_i[11:4];
            end
            // Hardware set wins over a same-cycle clear
            if (resume_se0)
                transceiver_control[`UIM_PHY_RESET_CAUSE] <= 1'b1;
            else if (phy_clr && !reg_wdata_i[`UIM_PHY_RESET_CAUSE])
                transceiver_control[`UIM_PHY_RESET_CAUSE] <= 1'b0;
            if (resume_k)
                transceiver_control[`UIM_PHY_RESUME_CAUSE] <= 1'b1;
            else if (phy_clr && !reg_wdata_i[`UIM_PHY_RESUME_CAUSE])
                transceiver_control[`UIM_PHY_RESUME_CAUSE] <= 1'b0;
        end
    end

    // Transceiver pins from control register
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            transceiver_port_a_pulldown_o <= 1'b1;
            transceiver_port_b_pulldown_o <= 1'b1;
            transceiver_config_pins_o <= 3'h0;
            suspend_hw_o <= 1'b0;
        end
        else
        begin
            transceiver_port_a_pulldown_o <=
                ~transceiver_control[`UIM_PHY_PD_DISABLE];
            transceiver_port_b_pulldown_o <=
                ~transceiver_control[`UIM_PHY_PD_DISABLE];
            transceiver_config_pins_o <=
                transceiver_control[`UIM_PHY_CONF_LSB +: 3];
            suspend_hw_o <= susp_hw;
        end
    end

    // Read mux; reserved bits and unmapped offsets give zero
    reg [31:0] next_rdata;
    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (reg_addr_i)
            `UIM_OFF_SIGNAL_FLAG_SET: next_rdata[6:0] = signal_flag_set;
            `UIM_OFF_FLAG_STICKY_SELECT: next_rdata[6:0] = flag_sticky_select;
            `UIM_OFF_FLAG_PORT_MASKS: next_rdata[23:0] = flag_port_masks;
            `UIM_OFF_FRAME_START_COUNT: next_rdata[10:0] = frame_start_count;
            `UIM_OFF_LAST_PACKET_ID: next_rdata[3:0] = last_packet_id;
            `UIM_OFF_LAST_ENDPOINT:
                next_rdata[4:0] = {last_endpoint_valid, last_endpoint};
            `UIM_OFF_ENDPOINT_SPECIAL_MARK: next_rdata[15:0] = endpoint_special_mark;
            `UIM_OFF_OTG_FLAG_MASK: next_rdata = otg_flag_mask_o;
            `UIM_OFF_POWER_SIGNAL_WORD: next_rdata[8:0] = power_signal_o;
            `UIM_OFF_TRANSCEIVER_CONTROL: next_rdata[18:0] = transceiver_control;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data registered one cycle after the strobe
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (reg_rd_i)
            reg_rdata_o <= next_rdata;
    end

endmodule // uim_core

/* File: dv/uim_core_chk.sv */
// Port checker for the interface manager block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module uim_core_chk (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire [31:0] reg_rdata_o,
    input wire ep_valid_i,
    input wire [3:0] ep_i,
    input wire [1:0] linestate_i,
    input wire [4:0] rx_ep_o,
    input wire [1:0] linestate_filt_o,
    input wire auto_resume_o,
    input wire suspend_hw_o,
    input wire transceiver_port_a_pulldown_o,
    input wire transceiver_port_b_pulldown_o,
    input wire [2:0] transceiver_config_pins_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    reg [31:0] ctl_q; // Last control word written
    wire ctl_wr = reg_wr_i && reg_addr_i == 8'h40;
    wire soft_wr = reg_wr_i && reg_addr_i == 8'h00;
    // Shadow of the control word, kept over soft reset
    always @(posedge sys_clk_i)
        if (!rst_n_i)
            ctl_q <= 32'h0;
        else if (ctl_wr)
            ctl_q <= reg_wdata_i;
    // Two cycles with no control write
    sequence s_ctl_quiet;
        !ctl_wr ##1 !ctl_wr;
    endsequence
    a_pulldown_follow: assert property (
        s_ctl_quiet |-> transceiver_port_a_pulldown_o == !ctl_q[18]
        && transceiver_port_b_pulldown_o == !ctl_q[18])
        else $error("pulldowns differ from control word");
    a_config_pins: assert property (
        s_ctl_quiet |-> transceiver_config_pins_o == ctl_q[6:4])
        else $error("config pins differ from control word");
    a_suspend_copy: assert property (
        s_ctl_quiet |-> suspend_hw_o == ctl_q[7])
        else $error("suspend handler output wrong");
    a_rdata_hold: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        reg_rd_i && (reg_addr_i > 8'h40 || reg_addr_i[1:0] != 2'h0)
        |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_ep_capture: assert property (
        ep_valid_i |=> rx_ep_o[3:0] == $past(ep_i))
        else $error("endpoint not captured");
    a_resume_pulse: assert property (
        auto_resume_o |-> suspend_hw_o ##1 !auto_resume_o)
        else $error("resume pulse wrong");
    a_filter_stable: assert property (
        $changed(linestate_filt_o) && !$past(soft_wr) && !$past(soft_wr, 2)
        |-> linestate_filt_o == $past(linestate_i))
        else $error("filtered linestate took unstable value");
endmodule // uim_core_chk
bind uim_core uim_core_chk i_chk (.*);

/* File: dv/uim_phy_model.sv */
// Transceiver and host model for the manager's receive side.
// Assumes the bench calls its tasks; drives change on falling edges.
`timescale 1ns/100ps
module uim_phy_model (
    input wire sys_clk_i,
    output logic rx_error_o,
    output logic rx_active_o,
    output logic crc16_fail_o,
    output logic token_ok_o,
    output logic pkt_start_o,
    output logic pid_valid_o,
    output logic [3:0] pid_o,
    output logic ep_valid_o,
    output logic [3:0] ep_o,
    output logic sof_valid_o,
    output logic [10:0] sof_frame_o,
    output logic [1:0] linestate_o,
    output logic suspend_o
);
    // Idle; line rests in J
    initial
    begin
        {rx_error_o, rx_active_o, crc16_fail_o, token_ok_o, pkt_start_o} = 5'h0;
        {pid_valid_o, ep_valid_o, sof_valid_o, suspend_o} = 4'h0;
        {pid_o, ep_o, sof_frame_o} = 19'h0;
        linestate_o = 2'h1;
    end
    // Line state and suspend level
    task line(input [1:0] ls, input sp);
        @(negedge sys_clk_i);
        linestate_o = ls;
        suspend_o = sp;
    endtask
    // Receive error level
    task err(input v);
        @(negedge sys_clk_i);
        rx_error_o = v;
    endtask
    // One received packet: start, then id, endpoint and status
    task packet(input [3:0] pid, input [3:0] ep, input bad, input tok);
        @(negedge sys_clk_i);
        {pkt_start_o, rx_active_o} = 2'h3;
        @(negedge sys_clk_i);
        {pkt_start_o, pid_valid_o, ep_valid_o} = 3'h3;
        {pid_o, ep_o, crc16_fail_o, token_ok_o} = {pid, ep, bad, tok};
        @(negedge sys_clk_i);
        {pid_valid_o, ep_valid_o, token_ok_o, crc16_fail_o, rx_active_o} = 5'h0;
        {pid_o, ep_o} = ~{pid, ep}; // Stale data is not held
    endtask
    // Start-of-frame with frame number
    task sof(input [10:0] f);
        @(negedge sys_clk_i);
        {sof_valid_o, sof_frame_o} = {1'b1, f};
        @(negedge sys_clk_i);
        {sof_valid_o, sof_frame_o} = {1'b0, ~f};
    endtask
endmodule // uim_phy_model

/* File: dv/uim_core_tb.sv */
// Self-checking bench for the interface manager block.
// Assumes the transceiver model and bound checker alongside.
`timescale 1ns/100ps
`define UIM_CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("mismatch %s exp %h got %h", what, exp, got); \
        end \
    end
module uim_core_tb;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] reg_rdata_o, otg_flag_mask_o;
    logic rx_error_i, rx_active_i, crc16_fail_i, token_ok_i, pkt_start_i;
    logic pid_valid_i, ep_valid_i, sof_valid_i, suspend_i, auto_resume_o;
    logic notify_port_a_o, notify_port_b_o, notify_port_c_o, suspend_hw_o;
    logic transceiver_port_a_pulldown_o, transceiver_port_b_pulldown_o;
    logic [3:0] pid_i, ep_i;
    logic [10:0] sof_frame_i;
    logic [1:0] linestate_i, linestate_filt_o;
    logic [4:0] rx_ep_o;
    logic [2:0] transceiver_config_pins_o;
    logic [8:0] power_signal_o;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Register offsets and readable bits after writing all ones
    logic [7:0] offs [9] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40};
    logic [31:0] msk [9] = '{32'h7f, 32'hff_ffff, 32'h7ff, 0, 0, 32'hffff, '1, 32'h1ff,
        32'h40ff0};
    uim_core i_dut (.*);
    uim_phy_model i_phy (
        .sys_clk_i(sys_clk_i),
        .rx_error_o(rx_error_i),
        .rx_active_o(rx_active_i),
        .crc16_fail_o(crc16_fail_i),
        .token_ok_o(token_ok_i),
        .pkt_start_o(pkt_start_i),
        .pid_valid_o(pid_valid_i),
        .pid_o(pid_i),
        .ep_valid_o(ep_valid_i),
        .ep_o(ep_i),
        .sof_valid_o(sof_valid_i),
        .sof_frame_o(sof_frame_i),
        .linestate_o(linestate_i),
        .suspend_o(suspend_i)
    );
    // 20 MHz clock
    initial
        forever #25 sys_clk_i = ~sys_clk_i;
    // Register write, 32-bit word, one cycle strobe
    task wr(input [7:0] a, input [31:0] d);
        @(negedge sys_clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
    endtask
    // Register read, data checked one cycle later
    task rdx(input [7:0] a, input [31:0] exp);
        @(negedge sys_clk_i);
        {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(negedge sys_clk_i);
        reg_rd_i = 1'b0;
        @(negedge sys_clk_i);
        `UIM_CHK("register", exp, reg_rdata_o)
    endtask
    task cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // Reset values, access kinds, reserved bits, control outputs
    task t_regs;
        for (int i = 0; i < 9; i++)
        begin
            rdx(offs[i], 32'h0);
            wr(offs[i], '1);
            rdx(offs[i], msk[i]);
        end
        wr(8'h44, '1);
        rdx(8'h44, 32'h0);
        `UIM_CHK("otg", 32'hffff_ffff, otg_flag_mask_o)
        `UIM_CHK("power", 9'h1ff, power_signal_o)
        `UIM_CHK("pins", 6'h0f, {transceiver_port_a_pulldown_o, transceiver_port_b_pulldown_o, suspend_hw_o, transceiver_config_pins_o})
        for (int i = 0; i < 9; i++)
            wr(offs[i], 32'h0);
        wr(8'h1c, 32'h7f);
        `UIM_CHK("pins", 6'h30, {transceiver_port_a_pulldown_o, transceiver_port_b_pulldown_o, suspend_hw_o, transceiver_config_pins_o})
        `UIM_CHK("otg", 32'h0, otg_flag_mask_o)
        `UIM_CHK("power", 9'h000, power_signal_o)
    endtask
    // Sticky and plain flags routed to the notify ports
    task t_flags;
        wr(8'h24, 32'h0001_4004);
        wr(8'h20, 32'h4);
        i_phy.packet(4'h1, 4'h1, 1'b1, 1'b1);
        cyc(2);
        `UIM_CHK("notify", 2'h3, {notify_port_a_o, notify_port_b_o})
        i_phy.packet(4'h2, 4'h2, 1'b0, 1'b0);
        cyc(2);
        `UIM_CHK("notify", 2'h2, {notify_port_a_o, notify_port_b_o})
        rdx(8'h1c, 32'h0c);
        wr(8'h1c, 32'h4);
        cyc(2);
        `UIM_CHK("notify", 1'b0, notify_port_a_o)
        i_phy.err(1'b1);
        cyc(3);
        `UIM_CHK("notify", 1'b1, notify_port_c_o)
        i_phy.err(1'b0);
        cyc(3);
        `UIM_CHK("notify", 1'b0, notify_port_c_o)
    endtask
    // Packet id, endpoint, marking, frame count, soft reset
    task t_capture;
        wr(8'h34, 32'h20);
        i_phy.packet(4'h9, 4'h5, 1'b0, 1'b0);
        rdx(8'h2c, 32'h9);
        rdx(8'h30, 32'h15);
        `UIM_CHK("rx_ep", 5'h15, rx_ep_o)
        i_phy.packet(4'h3, 4'h3, 1'b0, 1'b0);
        wr(8'h2c, 32'hf);
        rdx(8'h2c, 32'h3);
        `UIM_CHK("rx_ep", 5'h03, rx_ep_o)
        i_phy.sof(11'h5a3);
        rdx(8'h28, 32'h5a3);
        wr(8'h00, 32'h1);
        rdx(8'h30, 32'h0);
        rdx(8'h34, 32'h20);
    endtask
    // Linestate filter with four and one cycle windows, and a glitch
    task t_filter;
        wr(8'h40, 32'h200);
        i_phy.line(2'h2, 1'b0);
        cyc(2);
        `UIM_CHK("filt", 2'h1, linestate_filt_o)
        cyc(6);
        `UIM_CHK("filt", 2'h2, linestate_filt_o)
        i_phy.line(2'h1, 1'b0);
        cyc(2);
        i_phy.line(2'h2, 1'b0);
        cyc(8);
        `UIM_CHK("filt", 2'h2, linestate_filt_o)
        wr(8'h40, 32'h0);
        i_phy.line(2'h1, 1'b0);
        cyc(2);
        `UIM_CHK("filt", 2'h1, linestate_filt_o)
    endtask
    // Hardware resume from suspend, cause bits set and cleared
    task t_resume;
        wr(8'h40, 32'h80);
        i_phy.line(2'h2, 1'b1);
        for (int i = 0; i < 8 && auto_resume_o !== 1'b1; i++)
            @(negedge sys_clk_i);
        `UIM_CHK("resume", 1'b1, auto_resume_o)
        rdx(8'h40, 32'h1080);
        wr(8'h40, 32'h80);
        rdx(8'h40, 32'h80);
        i_phy.line(2'h0, 1'b1);
        cyc(4);
        rdx(8'h40, 32'h2080);
        wr(8'h40, 32'h80);
        rdx(8'h40, 32'h80);
        i_phy.line(2'h1, 1'b0);
    endtask
    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            print_verdict;
        end
    end
    // Main sequence
    initial
    begin
        repeat (5) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        `UIM_CHK("pulldown", 1'b1, transceiver_port_a_pulldown_o)
        t_regs;
        t_flags;
        t_capture;
        t_filter;
        t_resume;
        print_verdict;
    end
endmodule // uim_core_tb
